// File: core/ucc_ctrl.sv
// serial port control, configuration, break and flow control logic
`timescale 1ns/1ps
`default_nettype none
`include "ucc_cfg.svh"
// Functional notes
// - transmitter runs only while tx_on is set
// - receiver looks for start bits only while rx_on is set
// - rx_mute one puts receiver in silent mode, zero normal
// - with address wake, mute writes ignored while rx_full_flag is set
// - send_break sends break; hardware clears it at break stop position
// - lin mode: break becomes lin sync break, receiver detects lin breaks
// - stop field 00 one, 01 half, 10 two, 11 one and half bits
// - break irq when break_seen_flag and break_detect_irq_en both set
// - break_length_sel one gives 11-bit, zero 10-bit detection
// - four-bit own address wakes muted receiver on address match
// - cts irq when cts change flag and cts_change_irq_en set
// - cts_flow_on gates transmission from the cts input
// - rts_flow_on drives rts from receive buffer state
// - dma_tx_req_en refills transmit data by dma requests
// - dma_rx_req_en drains received data by dma requests
// - half_duplex_sel selects single-line half duplex
// - ir_low_power selects low-power infrared pulses
// - ir_mode_on selects infrared encoding on both paths
// - error irq on framing, overrun or noise with error_irq_en and rx dma
// - low-power ir clock divided by ir_clock_divider, zero reserved
// - wake bit one wakes on address mark, zero on idle line
// - rx_full_flag set when a character reaches the data register
// - cts change flag set on cts edge under flow control, cleared by zero
module ucc_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ucc_pkg::ucc_addr_t addr,
  input wire ucc_pkg::ucc_data_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output ucc_pkg::ucc_data_t rdata,
  input wire logic bit_tick,
  input wire logic rx_line,
  input wire logic rx_char_done,
  input wire logic rx_addr_char,
  input wire logic [3:0] rx_char_addr,
  input wire logic rx_idle_seen,
  input wire logic rx_data_read,
  input wire logic tx_empty,
  input wire logic framing_err_flag,
  input wire logic overrun_flag,
  input wire logic noise_flag,
  input wire logic cts_n,
  output logic tx_active,
  output logic rx_active,
  output logic rx_silent,
  output logic tx_break_low,
  output logic [2:0] stop_halves,
  output logic [9:0] ctl_mode,
  output logic rts_n,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic half_duplex,
  output logic ir_encode,
  output logic ir_lp_pulse,
  output logic ir_tick,
  output logic break_irq,
  output logic cts_irq,
  output logic error_irq
);
  import ucc_pkg::*;

  // ==========================================
  // register storage
  logic [13:2] ctl1_reg;
  logic rx_mute_reg;
  logic send_break_reg;
  logic [14:0] ctl2_reg;
  logic [10:0] ctl3_reg;
  logic [7:0] ir_clock_divider_reg;
  logic rx_full_flag_reg;
  logic cts_chg_reg;
  logic break_seen_flag_reg;
  logic cts_d_reg;
  ucc_data_t rdata_reg;
  ucc_data_t stat_word;
  ucc_bg_e bg_state_reg;
  logic [4:0] bg_cnt_reg;
  logic [4:0] lin_cnt_reg;
  logic [7:0] ir_cnt_reg;

  logic wr1, wr2, wr3, wrg, wrs;
  logic tx_on, rx_on, wake_addr, lin_mode_on;
  logic cts_flow_on, rts_flow_on, dma_tx_req_en, dma_rx_req_en;
  logic ir_mode_on, ir_low_power, error_irq_en;
  logic brk_done, cts_edge, lbd_hit, addr_match;
  logic [4:0] frame_low_bits;
  logic [4:0] lbd_thr;

  assign wr1 = wr_en && (addr == `UCC_OFF_CTL1);
  assign wr2 = wr_en && (addr == `UCC_OFF_CTL2);
  assign wr3 = wr_en && (addr == `UCC_OFF_CTL3);
  assign wrg = wr_en && (addr == `UCC_OFF_GPR);
  assign wrs = wr_en && (addr == `UCC_OFF_STAT);

  assign tx_on = ctl1_reg[`UCC_C1_TE];
  assign rx_on = ctl1_reg[`UCC_C1_RE];
  assign wake_addr = ctl1_reg[`UCC_C1_WAKE];
  assign lin_mode_on = ctl2_reg[`UCC_C2_LIN];
  assign cts_flow_on = ctl3_reg[`UCC_C3_CTS_FLOW_ON];
  assign rts_flow_on = ctl3_reg[`UCC_C3_RTS_FLOW_ON];
  assign dma_tx_req_en = ctl3_reg[`UCC_C3_DMA_TX_REQ_EN];
  assign dma_rx_req_en = ctl3_reg[`UCC_C3_DMA_RX_REQ_EN];
  assign ir_mode_on = ctl3_reg[`UCC_C3_IR_MODE_ON];
  assign ir_low_power = ctl3_reg[`UCC_C3_IR_LOW_POWER];
  assign error_irq_en = ctl3_reg[`UCC_C3_EIE];

  // ==========================================
  // control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_reg <= 12'(`UCC_RST_CTL1 >> 2);
    end else if (wr1) begin
      ctl1_reg <= wdata[13:2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl2_reg <= `UCC_RST_CTL2;
      ctl3_reg <= `UCC_RST_CTL3;
      ir_clock_divider_reg <= `UCC_RST_GPR;
    end else begin
      if (wr2) begin
        ctl2_reg <= wdata[14:0];
      end
      if (wr3) begin
        ctl3_reg <= wdata[10:0] & `UCC_C3_MASK;
      end
      if (wrg) begin
        ir_clock_divider_reg <= wdata[7:0];
      end
    end
  end

  // ==========================================
  // silent mode and wake-up
  assign addr_match = rx_char_addr == ctl2_reg[3:0];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_mute_reg <= 1'b0;
    end else if (rx_mute_reg && rx_on && !wake_addr && rx_idle_seen) begin
      rx_mute_reg <= 1'b0;
    end else if (rx_on && wake_addr && rx_addr_char) begin
      rx_mute_reg <= !addr_match;
    end else if (wr1 && !(wake_addr && rx_full_flag_reg)) begin
      rx_mute_reg <= wdata[`UCC_C1_MUTE];
    end
  end
  assign rx_silent = rx_mute_reg;

  // ==========================================
  // receive buffer flag, set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_flag_reg <= 1'b0;
    end else if (rx_char_done && rx_on && !rx_mute_reg) begin
      rx_full_flag_reg <= 1'b1;
    end else if (rx_data_read || (wrs && !wdata[`UCC_ST_RX_FULL_FLAG])) begin
      rx_full_flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // break generator, paced by bit ticks
  // lin breaks run longer than a frame so slaves can resync
  assign frame_low_bits = lin_mode_on ? `UCC_LIN_BRK_BITS :
                          5'(9 + ctl1_reg[`UCC_C1_M] + ctl1_reg[`UCC_C1_PCE]);
  assign brk_done = (bg_state_reg == UCC_BG_LOW) && bit_tick &&
                    (bg_cnt_reg == frame_low_bits - 5'h01);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bg_state_reg <= UCC_BG_IDLE;
      bg_cnt_reg <= 5'h00;
    end else begin
      case (bg_state_reg)
        UCC_BG_IDLE: begin
          if (send_break_reg && tx_active && bit_tick) begin
            bg_state_reg <= UCC_BG_LOW;
            bg_cnt_reg <= 5'h00;
          end
        end
        UCC_BG_LOW: begin
          if (brk_done) begin
            bg_state_reg <= UCC_BG_STOP;
          end else if (bit_tick) begin
            bg_cnt_reg <= bg_cnt_reg + 5'h01;
          end
        end
        UCC_BG_STOP: begin
          if (bit_tick) begin
            bg_state_reg <= UCC_BG_IDLE;
          end
        end
        default: begin
          bg_state_reg <= UCC_BG_IDLE;
        end
      endcase
    end
  end
  assign tx_break_low = bg_state_reg == UCC_BG_LOW;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      send_break_reg <= 1'b0;
    end else if (brk_done) begin
      send_break_reg <= 1'b0;
    end else if (wr1) begin
      send_break_reg <= wdata[`UCC_C1_BRK];
    end
  end

  // ==========================================
  // lin break detection
  assign lbd_thr = ctl2_reg[`UCC_C2_BREAK_LENGTH_SEL] ? `UCC_LBD_LONG : `UCC_LBD_SHORT;
  assign lbd_hit = bit_tick && !rx_line && (lin_cnt_reg == lbd_thr - 5'h01);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_cnt_reg <= 5'h00;
    end else if (!(lin_mode_on && rx_on) || (bit_tick && rx_line)) begin
      lin_cnt_reg <= 5'h00;
    end else if (bit_tick && lin_cnt_reg != 5'h1F) begin
      lin_cnt_reg <= lin_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_seen_flag_reg <= 1'b0;
    end else if (lin_mode_on && rx_on && lbd_hit) begin
      break_seen_flag_reg <= 1'b1;
    end else if (wrs && !wdata[`UCC_ST_LBD]) begin
      break_seen_flag_reg <= 1'b0;
    end
  end

  // ==========================================
  // cts change detection
  assign cts_edge = cts_flow_on && (cts_n != cts_d_reg);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_d_reg <= 1'b1;
      cts_chg_reg <= 1'b0;
    end else begin
      cts_d_reg <= cts_n;
      if (cts_edge) begin
        cts_chg_reg <= 1'b1;
      end else if (wrs && !wdata[`UCC_ST_CTS]) begin
        cts_chg_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // infrared low-power clock divider
  // a zero divider is reserved, so the tick simply stops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_cnt_reg <= 8'h00;
    end else if (!(ir_mode_on && ir_low_power) || ir_clock_divider_reg == 8'h00) begin
      ir_cnt_reg <= 8'h00;
    end else if (ir_cnt_reg >= ir_clock_divider_reg - 8'h01) begin
      ir_cnt_reg <= 8'h00;
    end else begin
      ir_cnt_reg <= ir_cnt_reg + 8'h01;
    end
  end
  assign ir_tick = ir_mode_on && ir_low_power && ir_clock_divider_reg != 8'h00 &&
                   ir_cnt_reg == ir_clock_divider_reg - 8'h01;

  // ==========================================
  // mode outputs and requests
  assign tx_active = tx_on && !(cts_flow_on && cts_n);
  assign rx_active = rx_on;
  assign ctl_mode = ctl1_reg[13:4];
  assign half_duplex = ctl3_reg[`UCC_C3_HD];
  assign ir_encode = ir_mode_on;
  assign ir_lp_pulse = ir_mode_on && ir_low_power;
  assign rts_n = rts_flow_on && rx_full_flag_reg;
  assign dma_tx_req = dma_tx_req_en && tx_on && tx_empty;
  assign dma_rx_req = dma_rx_req_en && rx_full_flag_reg;
  assign break_irq = break_seen_flag_reg && ctl2_reg[`UCC_C2_BREAK_DETECT_IRQ_EN];
  assign cts_irq = cts_chg_reg && ctl3_reg[`UCC_C3_CTS_CHANGE_IRQ_EN];
  assign error_irq = error_irq_en && dma_rx_req_en &&
                     (framing_err_flag || overrun_flag || noise_flag);

  always_comb begin
    case (ctl2_reg[`UCC_C2_STOP_HI:`UCC_C2_STOP_LO])
      2'b00: stop_halves = 3'h2;
      2'b01: stop_halves = 3'h1;
      2'b10: stop_halves = 3'h4;
      2'b11: stop_halves = 3'h3;
      default: stop_halves = 3'h2;
    endcase
  end

  // ==========================================
  // read port, data one cycle after the strobe
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`UCC_ST_CTS] = cts_chg_reg;
    stat_word[`UCC_ST_LBD] = break_seen_flag_reg;
    stat_word[`UCC_ST_TXE] = tx_empty;
    stat_word[`UCC_ST_RX_FULL_FLAG] = rx_full_flag_reg;
    stat_word[`UCC_ST_ORE] = overrun_flag;
    stat_word[`UCC_ST_NE] = noise_flag;
    stat_word[`UCC_ST_FE] = framing_err_flag;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        `UCC_OFF_STAT: rdata_reg <= stat_word;
        `UCC_OFF_CTL1: rdata_reg <= {18'h00000, ctl1_reg, rx_mute_reg, send_break_reg};
        `UCC_OFF_CTL2: rdata_reg <= {17'h00000, ctl2_reg};
        `UCC_OFF_CTL3: rdata_reg <= {21'h000000, ctl3_reg};
        `UCC_OFF_GPR: rdata_reg <= {24'h000000, ir_clock_divider_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign rdata = rdata_reg;

  // ==========================================
  // checks
  property p_tx_gate;
    @(posedge core_clk) disable iff (!rst_n)
      tx_active |-> tx_on && !(cts_flow_on && cts_n);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx active while gated");

  property p_mute_lock;
    @(posedge core_clk) disable iff (!rst_n)
      wr1 && wake_addr && rx_full_flag_reg && !rx_addr_char && !rx_idle_seen
      |=> $stable(rx_mute_reg);
  endproperty
  a_mute_lock: assert property (p_mute_lock) else $error("mute changed while locked");

  property p_brk_clear;
    @(posedge core_clk) disable iff (!rst_n)
      brk_done |=> !send_break_reg && bg_state_reg == UCC_BG_STOP;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break bit not cleared");

  property p_brk_len;
    @(posedge core_clk) disable iff (!rst_n) tx_break_low && bit_tick && !brk_done |=> tx_break_low;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break cut short");

  property p_rx_full_flag_set;
    @(posedge core_clk) disable iff (!rst_n)
      rx_char_done && rx_on && !rx_mute_reg |=> rx_full_flag_reg;
  endproperty
  a_rx_full_flag_set: assert property (p_rx_full_flag_set) else $error("rx full not set");

  property p_lbd;
    @(posedge core_clk) disable iff (!rst_n)
      lin_mode_on && rx_on && lbd_hit |=> break_seen_flag_reg;
  endproperty
  a_lbd: assert property (p_lbd) else $error("lin break missed");

  property p_lbd_irq;
    @(posedge core_clk) disable iff (!rst_n)
      break_irq == (break_seen_flag_reg && ctl2_reg[`UCC_C2_BREAK_DETECT_IRQ_EN]);
  endproperty
  a_lbd_irq: assert property (p_lbd_irq) else $error("break irq wrong");

  property p_cts_flag;
    @(posedge core_clk) disable iff (!rst_n)
      cts_flow_on && (cts_n != $past(cts_n)) && $past(rst_n) |=> cts_chg_reg;
  endproperty
  a_cts_flag: assert property (p_cts_flag) else $error("cts change missed");

  property p_rts;
    @(posedge core_clk) disable iff (!rst_n)
      rts_flow_on && rx_data_read && !rx_char_done |=> !rts_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts not released");

  property p_err_irq;
    @(posedge core_clk) disable iff (!rst_n)
      error_irq |-> error_irq_en && dma_rx_req_en;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq ungated");

  property p_stop;
    @(posedge core_clk) disable iff (!rst_n)
      ctl2_reg[13:12] == 2'b01 |-> stop_halves == 3'h1;
  endproperty
  a_stop: assert property (p_stop) else $error("half stop decode");
endmodule
`default_nettype wire

// File: common/ucc_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH
`define UCC_OFF_STAT 8'h00
`define UCC_OFF_CTL1 8'h0C
`define UCC_OFF_CTL2 8'h10
`define UCC_OFF_CTL3 8'h14
`define UCC_OFF_GPR 8'h18
`define UCC_RST_CTL1 14'h0000
`define UCC_RST_CTL2 15'h0000
`define UCC_RST_CTL3 11'h000
`define UCC_RST_GPR 8'h00
`define UCC_C1_M 12
`define UCC_C1_WAKE 11
`define UCC_C1_PCE 10
`define UCC_C1_TE 3
`define UCC_C1_RE 2
`define UCC_C1_MUTE 1
`define UCC_C1_BRK 0
`define UCC_C2_LIN 14
`define UCC_C2_STOP_HI 13
`define UCC_C2_STOP_LO 12
`define UCC_C2_BREAK_DETECT_IRQ_EN 6
`define UCC_C2_BREAK_LENGTH_SEL 5
`define UCC_C3_CTS_CHANGE_IRQ_EN 10
`define UCC_C3_CTS_FLOW_ON 9
`define UCC_C3_RTS_FLOW_ON 8
`define UCC_C3_DMA_TX_REQ_EN 7
`define UCC_C3_DMA_RX_REQ_EN 6
`define UCC_C3_HD 3
`define UCC_C3_IR_LOW_POWER 2
`define UCC_C3_IR_MODE_ON 1
`define UCC_C3_EIE 0
`define UCC_C3_MASK 11'h7CF
`define UCC_ST_CTS 9
`define UCC_ST_LBD 8
`define UCC_ST_TXE 7
`define UCC_ST_RX_FULL_FLAG 5
`define UCC_ST_ORE 3
`define UCC_ST_NE 2
`define UCC_ST_FE 1
`define UCC_LBD_SHORT 5'h0A
`define UCC_LBD_LONG 5'h0B
`define UCC_LIN_BRK_BITS 5'h0D
`endif

// File: common/ucc_pkg.sv
// types shared by the serial port control block
package ucc_pkg;
  typedef logic [7:0] ucc_addr_t;
  typedef logic [31:0] ucc_data_t;
  typedef enum logic [2:0] {
    UCC_BG_IDLE = 3'b001,
    UCC_BG_LOW = 3'b010,
    UCC_BG_STOP = 3'b100
  } ucc_bg_e;
endpackage

// File: testbench/ucc_line_model.sv
// far side model: baud tick source and receive line driver
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// line model
module ucc_line_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start_low,
  input wire logic [4:0] low_ticks,
  output logic bit_tick,
  output logic rx_line
);
  logic [3:0] div_reg;
  logic [4:0] low_reg;
  // one pulse every TICK_DIV clocks, like the outside baud divider
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (div_reg == 4'(TICK_DIV - 1));
      div_reg <= (div_reg == 4'(TICK_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
    end
  end
  // line held low for exactly low_ticks bit ticks, then back to idle high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_reg <= 5'h00;
    end else if (start_low) begin
      low_reg <= low_ticks;
    end else if (bit_tick && low_reg != 5'h00) begin
      low_reg <= low_reg - 5'h01;
    end
  end
  assign rx_line = (low_reg == 5'h00);
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`include "ucc_cfg.svh"
module tb;
  import ucc_pkg::*;
  typedef struct {ucc_addr_t a; ucc_data_t w; ucc_data_t r; logic [5:0] o;} ucc_row_s;
  // ==========================================
  // signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ucc_addr_t addr = '0;
  ucc_data_t wdata = '0;
  logic wr_en = 0, rd_en = 0, rx_char_done = 0, rx_addr_char = 0, rx_idle_seen = 0;
  logic rx_data_read = 0, tx_empty = 1, framing_err_flag = 0, overrun_flag = 0;
  logic noise_flag = 0, cts_n = 0, start_low = 0;
  logic [3:0] rx_char_addr = 4'h0;
  logic [4:0] low_ticks = 5'h00;
  ucc_data_t rdata, v;
  logic bit_tick, rx_line, tx_active, rx_active, rx_silent, tx_break_low, rts_n;
  logic dma_tx_req, dma_rx_req, half_duplex, ir_encode, ir_lp_pulse, ir_tick;
  logic break_irq, cts_irq, error_irq;
  logic [2:0] stop_halves;
  logic [9:0] ctl_mode;
  int n_errors = 0, n_compared = 0, cyc = 0, brk = 0, irt = 0, i;
  ucc_addr_t offs [4] = '{`UCC_OFF_CTL1, `UCC_OFF_CTL2, `UCC_OFF_CTL3, `UCC_OFF_GPR};
  ucc_row_s rows [14] = '{
    '{`UCC_OFF_CTL2, 32'h0, 32'h0, 6'h10}, '{`UCC_OFF_CTL2, 32'h1000, 32'h1000, 6'h08},
    '{`UCC_OFF_CTL2, 32'h2000, 32'h2000, 6'h20}, '{`UCC_OFF_CTL2, 32'h3000, 32'h3000, 6'h18},
    '{`UCC_OFF_CTL2, 32'hFFFFFFFF, 32'h7FFF, 6'h18}, '{`UCC_OFF_CTL2, 32'h0, 32'h0, 6'h10},
    '{`UCC_OFF_CTL3, 32'h8, 32'h8, 6'h14}, '{`UCC_OFF_CTL3, 32'h2, 32'h2, 6'h12},
    '{`UCC_OFF_CTL3, 32'h6, 32'h6, 6'h13}, '{`UCC_OFF_CTL3, 32'hFFFFFFFF, 32'h7CF, 6'h17},
    '{`UCC_OFF_CTL3, 32'h0, 32'h0, 6'h10}, '{`UCC_OFF_GPR, 32'hFFFFFFFF, 32'hFF, 6'h10},
    '{8'h20, 32'hFFFFFFFF, 32'h0, 6'h10}, '{8'h04, 32'hFFFFFFFF, 32'h0, 6'h10}};
  // break rows: extra ctl1 bits, ctl2, bit times low
  ucc_data_t bk_c1 [3] = '{32'h0, 32'h1400, 32'h0};
  ucc_data_t bk_c2 [3] = '{32'h0, 32'h0, 32'h4000};
  int bk_n [3] = '{9, 11, 13};
  // lin detect rows: ctl1, ctl2, low ticks, irq, flag
  ucc_data_t ld_c1 [6] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h0};
  ucc_data_t ld_c2 [6] = '{32'h4040, 32'h4040, 32'h4060, 32'h4060, 32'h4000, 32'h4060};
  logic [4:0] ld_n [6] = '{5'h09, 5'h0A, 5'h0A, 5'h0B, 5'h0A, 5'h0B};
  logic ld_irq [6] = '{0, 1, 0, 1, 0, 0};
  logic ld_flg [6] = '{0, 1, 0, 1, 1, 0};
  // ==========================================
  // design and far side
  ucc_ctrl ucc_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .bit_tick(bit_tick), .rx_line(rx_line),
    .rx_char_done(rx_char_done), .rx_addr_char(rx_addr_char), .rx_char_addr(rx_char_addr),
    .rx_idle_seen(rx_idle_seen), .rx_data_read(rx_data_read), .tx_empty(tx_empty),
    .framing_err_flag(framing_err_flag), .overrun_flag(overrun_flag),
    .noise_flag(noise_flag), .cts_n(cts_n), .tx_active(tx_active), .rx_active(rx_active),
    .rx_silent(rx_silent), .tx_break_low(tx_break_low), .stop_halves(stop_halves),
    .ctl_mode(ctl_mode), .rts_n(rts_n), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
    .half_duplex(half_duplex), .ir_encode(ir_encode), .ir_lp_pulse(ir_lp_pulse),
    .ir_tick(ir_tick), .break_irq(break_irq), .cts_irq(cts_irq), .error_irq(error_irq));
  ucc_line_model ucc_line_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .start_low(start_low), .low_ticks(low_ticks), .bit_tick(bit_tick), .rx_line(rx_line));
  always #10 core_clk = ~core_clk;
  // pulses are counted from values settled before each edge
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (bit_tick === 1'b1 && tx_break_low === 1'b1) brk <= brk + 1;
    if (ir_tick === 1'b1) irt <= irt + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  // ==========================================
  // tasks
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input ucc_addr_t a, input ucc_data_t d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input ucc_addr_t a, output ucc_data_t d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task pulse(input int which, input logic [3:0] a);
    @(posedge core_clk);
    rx_char_addr <= a;
    case (which)
      0: rx_char_done <= 1'b1;
      1: rx_addr_char <= 1'b1;
      2: rx_idle_seen <= 1'b1;
      default: rx_data_read <= 1'b1;
    endcase
    @(posedge core_clk);
    {rx_char_done, rx_addr_char, rx_idle_seen, rx_data_read} <= 4'h0;
    settle(1);
  endtask
  task wait_brk(input logic lvl);
    for (i = 0; i < 120 && tx_break_low !== lvl; i++) settle(1);
    chk("break_wait", lvl, tx_break_low);
  endtask
  task end_of_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    settle(8);
    chk("rts_n_rst", 0, rts_n);
    chk("rdata_rst", 0, rdata);
    @(posedge core_clk) rst_n <= 1'b1;
    foreach (offs[k]) begin
      rd(offs[k], v);
      chk("reset_value", 0, v);
    end
    rd(`UCC_OFF_STAT, v);
    chk("status_rst", 32'h80, v);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, v);
      chk("readback", rows[k].r, v);
      chk("mode_outs", rows[k].o, {stop_halves, half_duplex, ir_encode, ir_lp_pulse});
    end
    wr(`UCC_OFF_CTL1, 32'h2000);
    settle(1);
    chk("ctl_mode", 10'h200, ctl_mode);
    wr(`UCC_OFF_CTL1, 32'h8);
    settle(1);
    chk("tx_active_on", 1, tx_active);
    wr(`UCC_OFF_CTL3, 32'h600);
    @(posedge core_clk) cts_n <= 1'b1;
    settle(3);
    chk("tx_blocked", 0, tx_active);
    chk("cts_irq", 1, cts_irq);
    rd(`UCC_OFF_STAT, v);
    chk("cts_flag", 1, v[`UCC_ST_CTS]);
    wr(`UCC_OFF_STAT, 32'h0);
    settle(1);
    chk("cts_clear", 0, cts_irq);
    wr(`UCC_OFF_CTL3, 32'h200);
    @(posedge core_clk) cts_n <= 1'b0;
    settle(3);
    chk("cts_irq_off", 0, cts_irq);
    chk("tx_unblocked", 1, tx_active);
    wr(`UCC_OFF_CTL1, 32'h0);
    settle(1);
    chk("tx_active_off", 0, tx_active);
    wr(`UCC_OFF_CTL1, 32'hC);
    wr(`UCC_OFF_CTL3, 32'h1C1);
    @(posedge core_clk) tx_empty <= 1'b0;
    settle(1);
    chk("dma_tx_full", 0, dma_tx_req);
    @(posedge core_clk) tx_empty <= 1'b1;
    settle(1);
    chk("dma_tx_empty", 1, dma_tx_req);
    pulse(0, 4'h0);
    chk("dma_rx_req", 1, dma_rx_req);
    chk("rts_held", 1, rts_n);
    for (int e = 0; e < 3; e++) begin
      @(posedge core_clk) {framing_err_flag, overrun_flag, noise_flag} <= 3'(1 << e);
      settle(1);
      chk("error_irq", 1, error_irq);
    end
    wr(`UCC_OFF_CTL3, 32'h101);
    settle(1);
    chk("error_irq_nodma", 0, error_irq);
    @(posedge core_clk) {framing_err_flag, overrun_flag, noise_flag} <= 3'h0;
    pulse(3, 4'h0);
    chk("rts_free", 0, rts_n);
    wr(`UCC_OFF_CTL3, 32'h0);
    wr(`UCC_OFF_CTL2, 32'h5);
    wr(`UCC_OFF_CTL1, 32'h806);
    settle(1);
    chk("silent", 1, rx_silent);
    chk("rx_active", 1, rx_active);
    pulse(1, 4'h3);
    chk("addr_miss", 1, rx_silent);
    pulse(0, 4'h0);
    rd(`UCC_OFF_STAT, v);
    chk("muted_char", 0, v[`UCC_ST_RX_FULL_FLAG]);
    pulse(1, 4'h5);
    chk("addr_hit", 0, rx_silent);
    pulse(0, 4'h0);
    wr(`UCC_OFF_CTL1, 32'h806);
    settle(1);
    chk("mute_locked", 0, rx_silent);
    pulse(3, 4'h0);
    wr(`UCC_OFF_CTL1, 32'h6);
    pulse(2, 4'h0);
    chk("idle_wake", 0, rx_silent);
    for (int b = 0; b < 3; b++) begin
      wr(`UCC_OFF_CTL2, bk_c2[b]);
      brk = 0;
      wr(`UCC_OFF_CTL1, 32'h9 | bk_c1[b]);
      wait_brk(1'b1);
      wait_brk(1'b0);
      settle(8);
      chk("break_len", bk_n[b], brk);
      rd(`UCC_OFF_CTL1, v);
      chk("break_done", 0, v[`UCC_C1_BRK]);
    end
    for (int d = 0; d < 6; d++) begin
      wr(`UCC_OFF_CTL1, ld_c1[d]);
      wr(`UCC_OFF_CTL2, ld_c2[d]);
      wr(`UCC_OFF_STAT, 32'h0);
      @(posedge core_clk);
      start_low <= 1'b1;
      low_ticks <= ld_n[d];
      @(posedge core_clk) start_low <= 1'b0;
      settle(4 * int'(ld_n[d]) + 12);
      chk("break_irq", ld_irq[d], break_irq);
      rd(`UCC_OFF_STAT, v);
      chk("break_flag", ld_flg[d], v[`UCC_ST_LBD]);
    end
    wr(`UCC_OFF_GPR, 32'h4);
    wr(`UCC_OFF_CTL3, 32'h6);
    settle(1);
    irt = 0;
    settle(40);
    chk("ir_ticks", 10, irt);
    wr(`UCC_OFF_GPR, 32'h0);
    settle(1);
    irt = 0;
    settle(40);
    chk("ir_ticks_zero", 0, irt);
    // normal infrared wants a divider of one and gives no low-power ticks
    wr(`UCC_OFF_GPR, 32'h1);
    wr(`UCC_OFF_CTL3, 32'h2);
    settle(1);
    irt = 0;
    settle(40);
    chk("ir_ticks_normal", 0, irt);
    wr(`UCC_OFF_CTL1, 32'h4);
    wr(`UCC_OFF_CTL3, 32'h100);
    pulse(0, 4'h0);
    chk("rts_n_pre", 1, rts_n);
    @(posedge core_clk) rst_n <= 1'b0;
    settle(2);
    chk("rts_n_midrst", 0, rts_n);
    chk("tx_midrst", 0, tx_active);
    @(posedge core_clk) rst_n <= 1'b1;
    rd(`UCC_OFF_CTL3, v);
    chk("ctl3_midrst", 0, v);
    end_of_test();
  end
endmodule
`default_nettype wire
